// [rtl/iep_map.svh]
// Register offsets, bit positions and reset values of the interrupt enable/priority block
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH
`define IEP_ADDR_ENABLE_PRI 8'ha8
`define IEP_ADDR_PRIO_PRI 8'hb8
`define IEP_ADDR_ENABLE_EXT 8'he6
`define IEP_ADDR_PRIO_EXT 8'hf6
`define IEP_RST_ENABLE_PRI 8'h00
`define IEP_RST_PRIO_PRI 8'h80
`define IEP_RST_ENABLE_EXT 8'h00
`define IEP_RST_PRIO_EXT 8'h00
`define IEP_BIT_GLOBAL 7
`define IEP_MASK_PRI_SRC 8'h7f
`define IEP_MASK_EXT_SRC 8'h1c
`define IEP_NUM_SRC 10
`define IEP_SRC_W 4
`endif

// [rtl/iep_pkg.sv]
// Types shared by the interrupt enable/priority block
package iep_pkg;
	// Access command on the register port: none, byte write, single-bit set or single-bit clear
	typedef enum logic [1:0] {
		IEP_OP_NONE = 2'b00,
		IEP_OP_BYTE = 2'b01,
		IEP_OP_SETB = 2'b10,
		IEP_OP_CLRB = 2'b11
	} iep_op_t;

	typedef struct packed {
		iep_op_t op;
		logic [7:0] addr;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} iep_wr_t;

	// Request offered to the CPU core
	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] src;
	} iep_req_t;
endpackage

// [rtl/iep_regs.sv]
// Interrupt enable and priority registers with request gating and arbitration
`timescale 1ns/10ps
`include "iep_map.svh"
module iep_regs #(
	parameter int NUM_SRC = `IEP_NUM_SRC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Register port from the CPU core
	input wire iep_pkg::iep_wr_t wr,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// Pending flags, same clock: ext0,tmr2,demod,rtc,ser,tmr3l,tmr3h,ext1,fc,soft0,soft1
	input wire logic ext_edge_source0,
	input wire logic timer_two_overflow,
	input wire logic temp_demodulator,
	input wire logic rtclock_flag,
	input wire logic output_serializer,
	input wire logic timer_three_low_overflow,
	input wire logic timer_three_high_overflow,
	input wire logic ext_edge_source1,
	input wire logic freq_count_done,
	input wire logic soft_source0,
	input wire logic soft_source1,
	// Service state from the CPU core
	input wire logic in_service_low,
	input wire logic in_service_high,
	// Request to the CPU core
	output iep_pkg::iep_req_t req
);
	logic [7:0] irq_enable_primary_q;
	logic [7:0] irq_enable_primary_d;
	logic [7:0] irq_priority_primary_q;
	logic [7:0] irq_priority_primary_d;
	logic [7:0] irq_enable_extended_q;
	logic [7:0] irq_enable_extended_d;
	logic [7:0] irq_priority_extended_q;
	logic [7:0] irq_priority_extended_d;
	logic [7:0] rd_data_q;
	iep_pkg::iep_req_t req_q;
	iep_pkg::iep_req_t req_d;

	wire logic [7:0] bit_mask = 8'h01 << wr.bit_idx;
	wire logic hit_en_pri = (wr.addr == `IEP_ADDR_ENABLE_PRI);
	wire logic hit_pr_pri = (wr.addr == `IEP_ADDR_PRIO_PRI);
	wire logic hit_en_ext = (wr.addr == `IEP_ADDR_ENABLE_EXT) && (wr.op == iep_pkg::IEP_OP_BYTE);
	wire logic hit_pr_ext = (wr.addr == `IEP_ADDR_PRIO_EXT) && (wr.op == iep_pkg::IEP_OP_BYTE);

	function automatic logic [7:0] apply_op(input logic [7:0] cur, input iep_pkg::iep_wr_t w,
		input logic [7:0] m);
		logic [7:0] r;
		r = cur;
		unique case (w.op)
			iep_pkg::IEP_OP_NONE: r = cur;
			iep_pkg::IEP_OP_BYTE: r = w.wdata;
			iep_pkg::IEP_OP_SETB: r = cur | m;
			iep_pkg::IEP_OP_CLRB: r = cur & ~m;
		endcase
		return r;
	endfunction

	assign irq_enable_primary_d = hit_en_pri ? apply_op(irq_enable_primary_q, wr, bit_mask) : irq_enable_primary_q;
	assign irq_priority_primary_d = hit_pr_pri ?
		(apply_op(irq_priority_primary_q, wr, bit_mask) | `IEP_RST_PRIO_PRI) : irq_priority_primary_q;
	assign irq_enable_extended_d = hit_en_ext ? (wr.wdata & `IEP_MASK_EXT_SRC) : irq_enable_extended_q;
	assign irq_priority_extended_d = hit_pr_ext ? (wr.wdata & `IEP_MASK_EXT_SRC) : irq_priority_extended_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_enable_primary_q <= `IEP_RST_ENABLE_PRI;
			irq_priority_primary_q <= `IEP_RST_PRIO_PRI;
			irq_enable_extended_q <= `IEP_RST_ENABLE_EXT;
			irq_priority_extended_q <= `IEP_RST_PRIO_EXT;
		end else begin
			irq_enable_primary_q <= irq_enable_primary_d;
			irq_priority_primary_q <= irq_priority_primary_d;
			irq_enable_extended_q <= irq_enable_extended_d;
			irq_priority_extended_q <= irq_priority_extended_d;
		end
	end

	wire logic [7:0] rd_mux = (rd_addr == `IEP_ADDR_ENABLE_PRI) ? irq_enable_primary_q :
		(rd_addr == `IEP_ADDR_PRIO_PRI) ? irq_priority_primary_q :
		(rd_addr == `IEP_ADDR_ENABLE_EXT) ? irq_enable_extended_q :
		(rd_addr == `IEP_ADDR_PRIO_EXT) ? irq_priority_extended_q : 8'h00;

	// Source list in fixed arbitration order, index 0 wins ties
	wire logic global_irq_enable = irq_enable_primary_q[`IEP_BIT_GLOBAL];
	logic [NUM_SRC-1:0] flag;
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] src_pr;
	// either timer three overflow half raises the one request
	assign flag = {soft_source1, soft_source0, freq_count_done, ext_edge_source1,
		timer_three_low_overflow | timer_three_high_overflow, output_serializer,
		rtclock_flag, temp_demodulator, timer_two_overflow, ext_edge_source0};
	assign src_en = {irq_enable_extended_q[4:2], irq_enable_primary_q[6:0]};
	assign src_pr = {irq_priority_extended_q[4:2], irq_priority_primary_q[6:0]};

	// gated level requests, flags never cleared here
	logic [NUM_SRC-1:0] gated;
	logic [NUM_SRC-1:0] gated_hi;
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			assign gated[g] = flag[g] & src_en[g] & global_irq_enable;
			assign gated_hi[g] = gated[g] & src_pr[g];
		end
	endgenerate

	// priority then fixed order, blocked by high service in progress, low requests also by low service
	always_comb begin
		logic [NUM_SRC-1:0] pool;
		logic hi;
		pool = '0;
		hi = 1'b0;
		req_d = '0;
		if (|gated_hi) begin
			pool = gated_hi;
			hi = 1'b1;
		end else begin
			pool = gated;
		end
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pool[i]) begin
				req_d.src = i[3:0];
			end
		end
		// Source and level stay visible while withheld; only valid is masked by service state
		req_d.high = hi;
		req_d.valid = (|pool) && !in_service_high && !(in_service_low && !hi);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			req_q <= '0;
			rd_data_q <= 8'h00;
		end else begin
			req_q <= req_d;
			rd_data_q <= rd_mux;
		end
	end

	assign req = req_q;
	assign rd_data = rd_data_q;

	a_global_off_blocks: assert property (@(posedge clk_sys) disable iff (srst)
		!global_irq_enable |=> !req_q.valid)
		else $error("request while globally disabled");
	a_enable_needed: assert property (@(posedge clk_sys) disable iff (srst)
		req_d.valid |-> src_en[req_d.src] && global_irq_enable)
		else $error("request from disabled source");
	a_prio_top_bit: assert property (@(posedge clk_sys) disable iff (srst)
		irq_priority_primary_q[7])
		else $error("primary priority top bit not one");
	a_ext_reserved: assert property (@(posedge clk_sys) disable iff (srst)
		(irq_enable_extended_q[7:5] == 3'h0) && (irq_priority_extended_q[7:5] == 3'h0))
		else $error("reserved bit set");
	sequence s_set_bit;
		wr.op == iep_pkg::IEP_OP_SETB && hit_en_pri;
	endsequence
	sequence s_clr_prio;
		wr.op == iep_pkg::IEP_OP_CLRB && hit_pr_pri && (wr.bit_idx != 3'h7);
	endsequence
	sequence s_ext_bit_op;
		(wr.op == iep_pkg::IEP_OP_SETB || wr.op == iep_pkg::IEP_OP_CLRB) &&
			(wr.addr == `IEP_ADDR_ENABLE_EXT || wr.addr == `IEP_ADDR_PRIO_EXT);
	endsequence
	a_bit_set: assert property (@(posedge clk_sys) disable iff (srst)
		s_set_bit |=> irq_enable_primary_q[$past(wr.bit_idx)])
		else $error("bit set lost");
	a_bit_clear: assert property (@(posedge clk_sys) disable iff (srst)
		s_clr_prio |=> !irq_priority_primary_q[$past(wr.bit_idx)])
		else $error("bit clear lost");
	a_ext_bit_refused: assert property (@(posedge clk_sys) disable iff (srst)
		s_ext_bit_op |=> $stable(irq_enable_extended_q) && $stable(irq_priority_extended_q))
		else $error("bit access changed an extended register");
	a_high_blocked: assert property (@(posedge clk_sys) disable iff (srst)
		$past(in_service_high) |-> !req_q.valid)
		else $error("high service preempted");
	a_low_withheld: assert property (@(posedge clk_sys) disable iff (srst)
		$past(in_service_low) && req_q.valid |-> req_q.high)
		else $error("low request during low service");
	a_high_first: assert property (@(posedge clk_sys) disable iff (srst)
		$past(|gated_hi) && req_q.valid |-> req_q.high)
		else $error("low chosen over high");
	a_pending_served: assert property (@(posedge clk_sys) disable iff (srst)
		(gated != '0) && !in_service_low && !in_service_high |=> req_q.valid)
		else $error("pending not raised");
	a_reset_clear: assert property (@(posedge clk_sys)
		!srst && $past(srst) |-> (irq_enable_primary_q == `IEP_RST_ENABLE_PRI) &&
			(irq_priority_primary_q == `IEP_RST_PRIO_PRI) && (irq_enable_extended_q == `IEP_RST_ENABLE_EXT) &&
			(irq_priority_extended_q == `IEP_RST_PRIO_EXT) && !req_q.valid)
		else $error("reset value");
endmodule

// [dv/iep_src_model.sv]
// Peripheral side: pending flags held until software clears them
`timescale 1ns/10ps
module iep_src_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Set and clear strobes from the bench
	input wire logic [10:0] set_f,
	input wire logic [10:0] clr_f,
	// Pending flags
	output logic [10:0] flags
);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flags <= 11'h000;
		end else begin
			flags <= (flags | set_f) & ~clr_f;
		end
	end
endmodule

// [dv/iep_regs_bench.sv]
// Self-checking bench for the interrupt enable and priority registers
`timescale 1ns/10ps
`include "iep_map.svh"
module iep_regs_bench;
	localparam logic [7:0] EP = `IEP_ADDR_ENABLE_PRI;
	localparam logic [7:0] PP = `IEP_ADDR_PRIO_PRI;
	localparam logic [7:0] EX = `IEP_ADDR_ENABLE_EXT;
	localparam logic [7:0] PX = `IEP_ADDR_PRIO_EXT;
	localparam iep_pkg::iep_op_t BY = iep_pkg::IEP_OP_BYTE;
	localparam iep_pkg::iep_op_t ST = iep_pkg::IEP_OP_SETB;
	localparam iep_pkg::iep_op_t CL = iep_pkg::IEP_OP_CLRB;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	iep_pkg::iep_wr_t wr = '0;
	logic [7:0] rd_addr = 8'h00;
	logic [7:0] rd_data;
	logic [10:0] set_f = 11'h000;
	logic [10:0] clr_f = 11'h000;
	logic [10:0] fl;
	logic svc_lo = 1'b0;
	logic svc_hi = 1'b0;
	iep_pkg::iep_req_t req;
	int mismatches = 0;
	int tests_run = 0;
	int s;
	always #2 clk_sys = ~clk_sys;
	iep_src_model u_iep_src_model (.clk_sys(clk_sys), .srst(srst), .set_f(set_f), .clr_f(clr_f), .flags(fl));
	iep_regs u_iep_regs (.clk_sys(clk_sys), .srst(srst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
		.ext_edge_source0(fl[0]), .timer_two_overflow(fl[1]), .temp_demodulator(fl[2]), .rtclock_flag(fl[3]),
		.output_serializer(fl[4]), .timer_three_low_overflow(fl[5]), .timer_three_high_overflow(fl[6]),
		.ext_edge_source1(fl[7]), .freq_count_done(fl[8]), .soft_source0(fl[9]), .soft_source1(fl[10]),
		.in_service_low(svc_lo), .in_service_high(svc_hi), .req(req));
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write held for one edge, then one idle cycle so writes never collide
	task automatic put(input iep_pkg::iep_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
		wr = '{op, a, b, d};
		@(negedge clk_sys);
		wr.op = iep_pkg::IEP_OP_NONE;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rd_addr = a;
		@(negedge clk_sys);
		chk(rd_data, exp);
	endtask
	task automatic rq(input logic v, input logic h, input logic [3:0] src);
		repeat (2) @(negedge clk_sys);
		chk({2'b00, req}, {2'b00, v, h, src});
	endtask
	task automatic fl_pulse(input logic [10:0] m, input logic set);
		if (set) begin
			set_f = m;
		end else begin
			clr_f = m;
		end
		@(negedge clk_sys);
		set_f = 11'h000;
		clr_f = 11'h000;
		// A free cycle keeps two pulses in a row out of one time step
		@(negedge clk_sys);
	endtask
	// Primary sources by bit access, extended ones by byte write
	task automatic gate(input int n, input logic [7:0] pa, input logic [7:0] ea, input logic on);
		if (n < 7) put(on ? ST : CL, pa, n[2:0], 8'h00);
		else put(BY, ea, 3'h0, on ? 8'h01 << (n - 5) : 8'h00);
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		rd(EP, 8'h00);
		rd(PP, 8'h80);
		rd(EX, 8'h00);
		rd(PX, 8'h00);
		put(BY, PP, 3'h0, 8'h00);
		rd(PP, 8'h80);
		put(CL, PP, 3'h7, 8'h00);
		rd(PP, 8'h80);
		put(BY, EX, 3'h0, 8'hfc);
		rd(EX, 8'h1c);
		put(BY, PX, 3'h0, 8'he0);
		rd(PX, 8'h00);
		put(ST, PX, 3'h2, 8'h00);
		rd(PX, 8'h00);
		put(BY, EX, 3'h0, 8'h00);
		put(ST, EP, 3'h7, 8'h00);
		rd(EP, 8'h80);
		$display("Test registers done");
		for (int f = 0; f < 11; f++) begin
			s = (f < 6) ? f : ((f == 6) ? 5 : f - 1);
			fl_pulse(11'h001 << f, 1'b1);
			rq(1'b0, 1'b0, 4'h0);
			gate(s, EP, EX, 1'b1);
			rq(1'b1, 1'b0, s[3:0]);
			gate(s, PP, PX, 1'b1);
			rq(1'b1, 1'b1, s[3:0]);
			gate(s, EP, EX, 1'b0);
			gate(s, PP, PX, 1'b0);
			rq(1'b0, 1'b0, 4'h0);
			fl_pulse(11'h001 << f, 1'b0);
		end
		rd(PP, 8'h80);
		$display("Test source gating done");
		fl_pulse(11'h401, 1'b1);
		gate(0, EP, EX, 1'b1);
		put(CL, EP, 3'h7, 8'h00);
		rq(1'b0, 1'b0, 4'h0);
		put(ST, EP, 3'h7, 8'h00);
		rq(1'b1, 1'b0, 4'h0);
		gate(9, EP, EX, 1'b1);
		gate(9, PP, PX, 1'b1);
		rq(1'b1, 1'b1, 4'h9);
		svc_lo = 1'b1;
		rq(1'b1, 1'b1, 4'h9);
		svc_hi = 1'b1;
		rq(1'b0, 1'b1, 4'h9);
		svc_lo = 1'b0;
		svc_hi = 1'b0;
		gate(9, PP, PX, 1'b0);
		rq(1'b1, 1'b0, 4'h0);
		svc_lo = 1'b1;
		rq(1'b0, 1'b0, 4'h0);
		svc_lo = 1'b0;
		fl_pulse(11'h001, 1'b0);
		rq(1'b1, 1'b0, 4'h9);
		$display("Test priority done");
		gate(9, PP, PX, 1'b1);
		put(ST, PP, 3'h3, 8'h00);
		srst = 1'b1;
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		rd(EP, 8'h00);
		rd(PP, 8'h80);
		rd(EX, 8'h00);
		rd(PX, 8'h00);
		rq(1'b0, 1'b0, 4'h0);
		$display("Test reset in mid-run done");
		stop_test();
	end
endmodule
